//--- dv/usbeps_core_tb.sv
// usbeps_core_tb: self-checking bench for the endpoint block
// assumes usbeps_link_model as the host side, APB master here
`timescale 1ns/1ps
`default_nettype none
module usbeps_core_tb;
  import usbeps_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite;
  logic              pready, pslverr, bus_reset, err;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, rd;
  usbeps_sof_s       sof;
  usbeps_setup_s     setup;
  logic [6:0]        fill, free, unf, ie, en, rwa, irq;
  usbeps_cfg_s [6:0] cfg;
  logic [6:0][10:0]  bbytes;
  int                mismatches, n_checks;

  usbeps_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .sof(sof),
    .bus_reset(bus_reset), .setup(setup), .bank_fill(fill),
    .bank_free(free), .ram_underflow(unf),
    .busy_bank_interrupt_enable(ie), .endpoint_enable_bit(en),
    .ep_cfg(cfg), .bank_bytes(bbytes), .read_write_allowed(rwa),
    .endpoint_interrupt(irq));

  usbeps_link_model link (.pclk(pclk), .sof(sof), .bus_reset(bus_reset),
    .setup(setup), .bank_fill(fill), .bank_free(free),
    .ram_underflow(unf));

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20)
    begin
      mismatches++;
      end_of_test();
    end
  endtask : apb

  task rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  function automatic logic [31:0] cw(int k, int d, int s, int b);
    return (k << KIND_LSB) | (d << DIR_BIT) | (s << SIZE_LSB) |
           (b << BANKS_BIT);
  endfunction : cw

  task t_regs;
    rdchk(ENABLE_OFS, ENABLE_RST);
    rdchk(FRAME_OFS, FRAME_RST);
    rdchk(STA_BASE, 32'h0);
    apb(1'b0, 12'h0F0, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, ENABLE_OFS, 32'h7F);
    rdchk(ENABLE_OFS, 32'h7F);
    for (int s = 0; s < 8; s++)
    begin
      apb(1'b1, CFG_BASE + 12'h8, cw(0, 0, s, 0));
      @(posedge pclk);
      chk(32'(bbytes[2]), 32'(MIN_BANK_BYTES) << s);
    end
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, CFG_BASE + 12'h4, cw(k, k % 2, 3, int'(k != 0)));
      rdchk(CFG_BASE + 12'h4, cw(k, k % 2, 3, int'(k != 0)));
    end
    apb(1'b1, CFG_BASE, cw(0, 0, 3, 0));
  endtask : t_regs

  task t_sof;
    link.sof_pulse(1'b0, 11'h5A5);
    rdchk(FRAME_OFS, 32'h5A5 << FRAME_NUMBER_FIELD_LSB);
    link.sof_pulse(1'b1, 11'h7FF);
    rdchk(FRAME_OFS, 32'h8000 | (32'h7FF << FRAME_NUMBER_FIELD_LSB));
    link.reset_pulse();
    rdchk(FRAME_OFS, 32'h0);
    rdchk(CFG_BASE + 12'h4, 32'h0);
    rdchk(CFG_BASE, cw(0, 0, 3, 0));
    apb(1'b1, ENABLE_OFS, 32'h7F);
    apb(1'b1, CFG_BASE + 12'h4, cw(2, 1, 3, 1));
    apb(1'b1, CFG_BASE + 12'h8, cw(2, 0, 0, 1));
  endtask : t_sof

  task t_busy;
    link.ev(0, 7'h02);
    rdchk(STA_BASE + 12'h4, 32'h5000);
    chk({31'h0, rwa[1]}, 32'h1);
    link.ev(0, 7'h02);
    link.ev(0, 7'h02);
    rdchk(STA_BASE + 12'h4, 32'h2000);
    link.ev(1, 7'h02);
    link.ev(1, 7'h02);
    link.ev(1, 7'h02);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq[1]}, 32'h1);
    rdchk(STA_BASE + 12'h4, 32'h0);
    link.ev(0, 7'h04);
    link.ev(0, 7'h04);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq[2]}, 32'h1);
    link.ev(1, 7'h04);
    rdchk(STA_BASE + 12'h8, 32'h5000);
  endtask : t_busy

  task t_setup_ram;
    link.setup_pulse(3'h0, 1'b1);
    rdchk(STA_BASE, 32'h20000);
    apb(1'b1, STA_BASE, 32'h0);
    rdchk(STA_BASE, 32'h20000);
    link.setup_pulse(3'h0, 1'b0);
    rdchk(STA_BASE, 32'h0);
    link.ev(2, 7'h02);
    rdchk(STA_BASE + 12'h4, 32'h800);
    rdchk(STA_CLR_BASE + 12'h4, 32'h0);
    apb(1'b1, STA_CLR_BASE + 12'h4, 32'hFFFFF7FF);
    rdchk(STA_BASE + 12'h4, 32'h800);
    apb(1'b1, STA_CLR_BASE + 12'h4, 32'h800);
    rdchk(STA_BASE + 12'h4, 32'h0);
  endtask : t_setup_ram

  task t_disable;
    link.ev(0, 7'h02);
    link.ev(2, 7'h02);
    apb(1'b1, ENABLE_OFS, 32'h7D);
    rdchk(STA_BASE + 12'h4, 32'h0);
    rdchk(CFG_BASE + 12'h4, cw(2, 1, 3, 1));
    chk({25'h0, cfg[1]}, 32'h57);
    chk({25'h0, en}, 32'h7D);
    link.ev(0, 7'h02);
    rdchk(STA_BASE + 12'h4, 32'h0);
  endtask : t_disable

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    ie = 7'h7F;
    mismatches = 0;
    n_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_sof();
    t_busy();
    t_setup_ram();
    t_disable();
    end_of_test();
  end
endmodule : usbeps_core_tb
`default_nettype wire

//--- dv/usbeps_link_model.sv
// usbeps_link_model: host-side event source for the endpoint block
// assumes one-cycle pulses sampled on the rising edge of pclk
`timescale 1ns/1ps
`default_nettype none
module usbeps_link_model
  import usbeps_pkg::*;
(
  input  wire logic                    pclk,
  output var usbeps_pkg::usbeps_sof_s   sof,
  output var logic                     bus_reset,
  output var usbeps_pkg::usbeps_setup_s setup,
  output var logic [6:0]               bank_fill,
  output var logic [6:0]               bank_free,
  output var logic [6:0]               ram_underflow
);
  initial
  begin
    sof = '0;
    bus_reset = 1'b0;
    setup = '0;
    bank_fill = '0;
    bank_free = '0;
    ram_underflow = '0;
  end

  task sof_pulse(input logic crc, input logic [10:0] fr);
    @(posedge pclk);
    sof <= '{1'b1, crc, fr};
    @(posedge pclk);
    sof <= '0;
  endtask : sof_pulse

  task reset_pulse;
    @(posedge pclk);
    bus_reset <= 1'b1;
    @(posedge pclk);
    bus_reset <= 1'b0;
  endtask : reset_pulse

  task setup_pulse(input logic [2:0] ep, input logic dir_in);
    @(posedge pclk);
    setup <= '{1'b1, ep, dir_in};
    @(posedge pclk);
    setup <= '0;
  endtask : setup_pulse

  // k: 0 bank filled, 1 bank freed, 2 RAM underflow
  task ev(input int k, input logic [6:0] m);
    @(posedge pclk);
    if (k == 0)
      bank_fill <= m;
    else if (k == 1)
      bank_free <= m;
    else
      ram_underflow <= m;
    @(posedge pclk);
    bank_fill <= '0;
    bank_free <= '0;
    ram_underflow <= '0;
  endtask : ev
endmodule : usbeps_link_model
`default_nettype wire

//--- hdl/usbeps_core.sv
// usbeps_core: endpoint enable, frame number capture, endpoint config
// and endpoint status with an APB register slave
// assumes link-side event pulses synchronous to pclk, one cycle each
//
// Function
// R1 - disable: ignore traffic, clear status, keep config
// R2 - enable bit set enables, reads back state
// R3 - last SOF frame number held in 13:3
// R4 - frame number updates even on corrupted SOF
// R5 - crc error flag bit 15, with SOF
// R6 - bus reset clears frame number and flag
// R7 - kind field 12:11, cleared by bus reset
// R8 - direction bit 8, OUT/IN, reset clears
// R9 - size code gives 8 to 1024 bytes
// R10 - bus reset clears size/banks except endpoint 0
// R11 - bank bit 2 selects one or two banks
// R12 - software gives control endpoints one bank
// R13 - control direction bit 17 set by SETUP
// R14 - current bank reads 00 or 01
// R15 - current bank follows allowed flag one cycle
// R16 - busy bank count in 13:12
// R17 - IN busy count, interrupt when all free
// R18 - OUT busy count, interrupt when all busy
// R19 - RAM underflow flag bit 11, write-one clear
// R20 - status clear register: ones clear, reads zero
// R21 - reserved bank encodings never produced
`timescale 1ns/1ps
`default_nettype none
module usbeps_core
  import usbeps_pkg::*;
(
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [11:0]                         paddr,
  input  wire logic [31:0]                         pwdata,
  output logic                                     pready,
  output logic [31:0]                              prdata,
  output logic                                     pslverr,
  input  wire usbeps_pkg::usbeps_sof_s             sof,
  input  wire logic                                bus_reset,
  input  wire usbeps_pkg::usbeps_setup_s           setup,
  input  wire logic [usbeps_pkg::NUM_EP-1:0]       bank_fill,
  input  wire logic [usbeps_pkg::NUM_EP-1:0]       bank_free,
  input  wire logic [usbeps_pkg::NUM_EP-1:0]       ram_underflow,
  input  wire logic [usbeps_pkg::NUM_EP-1:0]       busy_bank_interrupt_enable,
  output logic [usbeps_pkg::NUM_EP-1:0]            endpoint_enable_bit,
  output usbeps_pkg::usbeps_cfg_s [usbeps_pkg::NUM_EP-1:0] ep_cfg,
  output logic [usbeps_pkg::NUM_EP-1:0][10:0]      bank_bytes,
  output logic [usbeps_pkg::NUM_EP-1:0]            read_write_allowed,
  output logic [usbeps_pkg::NUM_EP-1:0]            endpoint_interrupt
);
  import usbeps_pkg::*;

  logic              wr_en;
  logic              setup_ph;
  logic [31:0]       next_rdata;
  logic              addr_err;
  logic [10:0]       frame_number_field;
  logic              frame_number_crc_error;
  logic [NUM_EP-1:0] en;
  usbeps_cfg_s       cfg       [NUM_EP];
  logic [1:0]        busy      [NUM_EP];
  logic [1:0]        cur_bank  [NUM_EP];
  logic              user_evt_q[NUM_EP];
  logic              ram_err   [NUM_EP];
  logic              ctrl_dir  [NUM_EP];
  logic [31:0]       cfg_word  [NUM_EP];
  logic [31:0]       sta_word  [NUM_EP];

  // zero-wait slave; read data captured in the setup phase
  assign pready   = 1'b1;
  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pwrite;
  assign pslverr  = psel & penable & addr_err;

  // read mux and address check
  always_comb
  begin
    next_rdata = 32'h00000000;
    addr_err   = 1'b1;
    if (paddr == ENABLE_OFS)
    begin
      next_rdata[NUM_EP-1:0] = en; // R2
      addr_err = 1'b0;
    end
    if (paddr == FRAME_OFS)
    begin
      next_rdata[FRAME_NUMBER_FIELD_LSB+:11]  = frame_number_field;
      next_rdata[FRAME_NUMBER_CRC_ERROR_BIT]    = frame_number_crc_error;
      addr_err = 1'b0;
    end
    for (int i = 0; i < NUM_EP; i++)
    begin
      if (paddr == CFG_BASE + 12'(i * 4))
      begin
        next_rdata = cfg_word[i];
        addr_err   = 1'b0;
      end
      if (paddr == STA_BASE + 12'(i * 4))
      begin
        next_rdata = sta_word[i];
        addr_err   = 1'b0;
      end
      if (paddr == STA_CLR_BASE + 12'(i * 4))
        addr_err = 1'b0; // R20
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup_ph)
      prdata <= pwrite ? 32'h00000000 : next_rdata;
  end

  // endpoint enable register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      en <= ENABLE_RST[NUM_EP-1:0];
    else if (wr_en && paddr == ENABLE_OFS)
      en <= pwdata[NUM_EP-1:0]; // R1 R2
  end
  assign endpoint_enable_bit = en;

  // frame number capture; bus reset wins over a SOF
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_number_field     <= FRAME_RST[FRAME_NUMBER_FIELD_LSB+:11];
      frame_number_crc_error <= FRAME_RST[FRAME_NUMBER_CRC_ERROR_BIT];
    end
    else if (bus_reset)
    begin
      frame_number_field     <= 11'h000; // R6
      frame_number_crc_error <= 1'b0; // R6
    end
    else if (sof.valid)
    begin
      frame_number_field     <= sof.frame; // R3 R4
      frame_number_crc_error <= sof.crc_err; // R5
    end
  end

  for (genvar n = 0; n < NUM_EP; n++)
  begin : g_ep
    localparam logic [11:0] CFG_A = CFG_BASE + 12'(n * 4);
    localparam logic [11:0] CLR_A = STA_CLR_BASE + 12'(n * 4);
    logic       act;
    logic       fill;
    logic       free;
    logic       user_evt;
    logic       is_ctrl;
    logic [1:0] nbanks;
    logic [1:0] next_busy;

    assign act      = en[n] & ~bus_reset;
    assign fill     = bank_fill[n] & act; // R1
    assign free     = bank_free[n] & act; // R1
    assign is_ctrl  = cfg[n].endpoint_kind == KIND_CONTROL;
    assign nbanks   = cfg[n].bank_count ? 2'h2 : 2'h1; // R11
    // user side owns the bank: IN fills it, OUT frees it
    assign user_evt = cfg[n].endpoint_direction ? fill : free;

    // configuration: kept on disable, partly cleared by bus reset
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        cfg[n] <= '0;
      else if (bus_reset)
      begin
        cfg[n].endpoint_kind      <= KIND_CONTROL; // R7
        cfg[n].endpoint_direction <= 1'b0; // R8
        if (n != 0)
        begin
          cfg[n].bank_size  <= 3'h0; // R10
          cfg[n].bank_count <= 1'b0; // R10
        end
      end
      else if (wr_en && paddr == CFG_A)
      begin
        cfg[n].endpoint_kind      <= usbeps_kind_e'(pwdata[KIND_LSB+:2]);
        cfg[n].endpoint_direction <= pwdata[DIR_BIT];
        cfg[n].bank_size          <= pwdata[SIZE_LSB+:3];
        cfg[n].bank_count         <= pwdata[BANKS_BIT];
      end
    end

    always_comb
    begin
      next_busy = busy[n];
      if (fill && !free && busy[n] < nbanks)
        next_busy = busy[n] + 2'h1;
      else if (free && !fill && busy[n] != 2'h0)
        next_busy = busy[n] - 2'h1;
    end

    // busy banks and the allowed flag move together
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        busy[n]               <= 2'h0;
        read_write_allowed[n] <= 1'b0;
        user_evt_q[n]         <= 1'b0;
      end
      else if (!en[n] || bus_reset)
      begin
        busy[n]               <= 2'h0; // R1
        read_write_allowed[n] <= 1'b0;
        user_evt_q[n]         <= 1'b0;
      end
      else
      begin
        busy[n] <= next_busy; // R16 R17 R18 R21
        read_write_allowed[n] <= cfg[n].endpoint_direction ?
                                 (next_busy < nbanks) : (next_busy != 2'h0);
        // only an accepted fill or free moves the current bank
        user_evt_q[n] <= user_evt & (next_busy != busy[n]) &
                         cfg[n].bank_count & ~is_ctrl;
      end
    end

    // current bank trails the allowed flag by one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        cur_bank[n] <= 2'h0;
      else if (!en[n] || bus_reset || is_ctrl || !cfg[n].bank_count)
        cur_bank[n] <= 2'h0; // R1 R14
      else if (user_evt_q[n])
        cur_bank[n] <= {1'b0, ~cur_bank[n][0]}; // R14 R15 R21
    end

    // underflow flag: the set wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        ram_err[n] <= 1'b0;
      else if (!en[n])
        ram_err[n] <= 1'b0; // R1
      else if (ram_underflow[n] && cfg[n].endpoint_direction && act)
        ram_err[n] <= 1'b1; // R19
      else if (wr_en && paddr == CLR_A && pwdata[RAMERR_BIT])
        ram_err[n] <= 1'b0; // R19 R20
    end

    // control direction taken from SETUP only, never from software
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        ctrl_dir[n] <= 1'b0;
      else if (!en[n])
        ctrl_dir[n] <= 1'b0; // R1
      else if (setup.valid && setup.ep == 3'(n) && act && is_ctrl)
        ctrl_dir[n] <= setup.dir_in; // R13
    end

    // endpoint interrupt on all-free (IN) or all-busy (OUT)
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        endpoint_interrupt[n] <= 1'b0;
      else
        endpoint_interrupt[n] <= en[n] & busy_bank_interrupt_enable[n] &
          (cfg[n].endpoint_direction ? (busy[n] == 2'h0)
                                     : (busy[n] == nbanks)); // R17 R18
    end

    always_comb
    begin
      cfg_word[n]                    = 32'h00000000;
      cfg_word[n][KIND_LSB+:2]       = cfg[n].endpoint_kind; // R7
      cfg_word[n][DIR_BIT]           = cfg[n].endpoint_direction; // R8
      cfg_word[n][SIZE_LSB+:3]       = cfg[n].bank_size; // R9
      cfg_word[n][BANKS_BIT]         = cfg[n].bank_count; // R11
      sta_word[n]                    = 32'h00000000;
      sta_word[n][CONTROL_DIRECTION_BIT]       = ctrl_dir[n];
      sta_word[n][CURRENT_BANK_LSB+:2]     = cur_bank[n];
      sta_word[n][BUSY_LSB+:2]       = busy[n]; // R16
      sta_word[n][RAMERR_BIT]        = ram_err[n];
    end

    assign ep_cfg[n]     = cfg[n];
    assign bank_bytes[n] = MIN_BANK_BYTES << cfg[n].bank_size; // R9

    busy_range_a: assert property (@(posedge pclk) disable iff (!presetn)
      busy[n] != 2'h3 && busy[n] <= nbanks) // R21
      else $error("busy bank count out of range");
    curbank_code_a: assert property (@(posedge pclk) disable iff (!presetn)
      !cur_bank[n][1] && (!is_ctrl || !$past(is_ctrl)
      || cur_bank[n] == 2'h0)) // R14
      else $error("current bank reserved or set on control");
    disable_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      !en[n] |=> busy[n] == 2'h0 && !ram_err[n] && !ctrl_dir[n]) // R1
      else $error("disabled endpoint kept status");
    underflow_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      ram_underflow[n] && act && cfg[n].endpoint_direction |=> ram_err[n])
      // R19
      else $error("underflow did not set flag");
    in_int_a: assert property (@(posedge pclk) disable iff (!presetn)
      en[n] && busy_bank_interrupt_enable[n] && cfg[n].endpoint_direction
      && busy[n] == 2'h0 |=> endpoint_interrupt[n]) // R17
      else $error("IN all-free interrupt missing");
  end

  frame_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
    sof.valid && !bus_reset |=> frame_number_field == $past(sof.frame)
    && frame_number_crc_error == $past(sof.crc_err)) // R4
    else $error("frame number not captured");
  bus_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_reset |=> frame_number_field == 11'h000 && !frame_number_crc_error
    && cfg[1].endpoint_kind == KIND_CONTROL && cfg[1].bank_size == 3'h0)
    // R6
    else $error("bus reset did not clear state");
  ep0_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
    bus_reset |=> cfg[0].bank_size == $past(cfg[0].bank_size)
    && cfg[0].bank_count == $past(cfg[0].bank_count)) // R10
    else $error("endpoint 0 size lost on bus reset");
  ctrl_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup.valid && setup.ep == 3'h0 && en[0] && !bus_reset
    && cfg[0].endpoint_kind == KIND_CONTROL
    |=> sta_word[0][CONTROL_DIRECTION_BIT] == $past(setup.dir_in)) // R13
    else $error("control direction not taken");
  clr_reads_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && paddr == STA_CLR_BASE |-> prdata == 32'h0)
    // R20
    else $error("clear register read nonzero");
  enable_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && paddr == ENABLE_OFS
    |-> prdata[NUM_EP-1:0] == en) // R2
    else $error("enable readback wrong");

  sof_c: cover property (@(posedge pclk) disable iff (!presetn)
    sof.valid && sof.crc_err);
  two_busy_c: cover property (@(posedge pclk) disable iff (!presetn)
    busy[1] == 2'h2);
  bank_swap_c: cover property (@(posedge pclk) disable iff (!presetn)
    cur_bank[1] == 2'h1);
  setup_in_c: cover property (@(posedge pclk) disable iff (!presetn)
    ctrl_dir[0]);

endmodule : usbeps_core
`default_nettype wire

//--- hdl/usbeps_pkg.sv
// usbeps_pkg: shared constants and carriers of the endpoint config/status block
// assumes a 12-bit APB byte address and seven endpoints
package usbeps_pkg;

  localparam int unsigned NUM_EP = 7;

  // register byte offsets
  localparam logic [11:0] ENABLE_OFS   = 12'h01C;
  localparam logic [11:0] FRAME_OFS    = 12'h020;
  localparam logic [11:0] CFG_BASE     = 12'h100;
  localparam logic [11:0] STA_BASE     = 12'h130;
  localparam logic [11:0] STA_CLR_BASE = 12'h160;
  localparam logic [11:0] EP_STRIDE    = 12'h004;

  // reset values
  localparam logic [31:0] ENABLE_RST = 32'h00000000;
  localparam logic [31:0] FRAME_RST  = 32'h00000000;

  // field positions
  localparam int FRAME_NUMBER_FIELD_LSB    = 3;
  localparam int FRAME_NUMBER_CRC_ERROR_BIT  = 15;
  localparam int KIND_LSB    = 11;
  localparam int DIR_BIT     = 8;
  localparam int SIZE_LSB    = 4;
  localparam int BANKS_BIT   = 2;
  localparam int CONTROL_DIRECTION_BIT = 17;
  localparam int CURRENT_BANK_LSB  = 14;
  localparam int BUSY_LSB    = 12;
  localparam int RAMERR_BIT  = 11;

  localparam logic [10:0] MIN_BANK_BYTES = 11'h008;

  typedef enum logic [1:0] {
    KIND_CONTROL = 2'h0,
    KIND_ISO     = 2'h1,
    KIND_BULK    = 2'h2,
    KIND_INTR    = 2'h3
  } usbeps_kind_e;

  typedef struct packed {
    usbeps_kind_e endpoint_kind;
    logic         endpoint_direction;
    logic [2:0]   bank_size;
    logic         bank_count;
  } usbeps_cfg_s;

  typedef struct packed {
    logic        valid;
    logic        crc_err;
    logic [10:0] frame;
  } usbeps_sof_s;

  typedef struct packed {
    logic       valid;
    logic [2:0] ep;
    logic       dir_in;
  } usbeps_setup_s;

endpackage : usbeps_pkg
